// File: src/mxd_datapath.sv
/*
 * Execute datapath tail of an 8-bit controller: subtract, swap, zero
 * skips, table reads, logic, add, clear, complement, decimal adjust,
 * increment/decrement, move and rotate, with accumulator and flags.
 * Assumes the decoder presents one operation with its memory operand
 * while op_ready is high, and program memory answers to
 * pm_rd_q in the same cycle as pm_rd_q is high, with pm_rdata.
 */
`timescale 1ns/1ps
`include "mxd_params.svh"

module mxd_datapath #(
    parameter int SECT_W = 3,
    parameter int PM_AW = 12
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic op_valid,
    output logic op_ready,
    input wire mxd_pkg::mxd_op_t op_code,
    input wire logic op_to_acc,
    input wire logic op_use_imm,
    input wire logic op_ext,
    input wire logic op_tbl_last,
    input wire logic op_tbl_preinc,
    input wire logic [2:0] op_bit,
    input wire logic [7:0] op_imm,
    input wire logic [7:0] op_addr,
    input wire logic [SECT_W-1:0] op_sect,
    input wire logic [SECT_W-1:0] bank_sel,
    input wire logic [7:0] op_mem_data,
    input wire logic tp_low_we,
    input wire logic tp_high_we,
    input wire logic [7:0] tp_wdata,
    input wire logic [15:0] pm_rdata,
    output logic mem_we_q,
    output logic [SECT_W+7:0] mem_waddr_q,
    output logic [7:0] mem_wdata_q,
    output logic pm_rd_q,
    output logic [PM_AW-1:0] pm_addr_q,
    output logic [7:0] acc_q,
    output logic [7:0] table_pointer_low_q,
    output logic [7:0] table_pointer_high_q,
    output logic [7:0] table_high_latch_q,
    output logic borrow_inverse_flag_q,
    output logic nibble_carry_flag_q,
    output logic signed_wrap_flag_q,
    output logic all_bits_null_flag_q,
    output logic signed_borrow_status_q,
    output logic chained_null_status_q,
    output logic dummy_cycle_q,
    output logic op_done_q
);
    import mxd_pkg::*;

    // -------------------------------------------------------------
    // Arithmetic helper
    // -------------------------------------------------------------
    // Returns {overflow, nibble carry, carry, sum}
    function automatic logic [10:0] add8(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic cin);
        logic [4:0] lo;
        logic [8:0] s;
        logic wrap;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        wrap = (a[7] == b[7]) && (s[7] != a[7]);
        return {wrap, lo[4], s[8], s[7:0]};
    endfunction

    mxd_state_t state_q;
    logic start;
    logic [7:0] opnd_b;
    logic [7:0] res_d;
    logic [10:0] ar;
    logic acc_wr_d;
    logic mem_wr_d;
    logic skip_d;
    logic arith_d;
    logic subtract_d;
    logic null_wr_d;
    logic carry_wr_d;
    logic carry_d;
    logic [7:0] bcd_adj;
    logic [8:0] bcd_sum;
    logic [7:0] tp_low_next;

    assign op_ready = (state_q == ST_IDLE);
    assign start = op_valid && op_ready;
    assign opnd_b = op_use_imm ? op_imm : op_mem_data;
    assign tp_low_next = table_pointer_low_q + 8'h01;

    // -------------------------------------------------------------
    // Operation decode and result
    // -------------------------------------------------------------
    always_comb begin
        res_d = op_mem_data;
        acc_wr_d = 1'b0;
        mem_wr_d = 1'b0;
        skip_d = 1'b0;
        arith_d = 1'b0;
        subtract_d = 1'b0;
        null_wr_d = 1'b0;
        carry_wr_d = 1'b0;
        carry_d = borrow_inverse_flag_q;
        bcd_adj = 8'h00;
        bcd_sum = 9'h000;
        ar = 11'h000;
        case (op_code)
            OP_SUB: begin
                ar = add8(acc_q, ~opnd_b, 1'b1);
                res_d = ar[7:0];
                arith_d = 1'b1;
                subtract_d = 1'b1;
                acc_wr_d = op_to_acc || op_use_imm;
                mem_wr_d = !(op_to_acc || op_use_imm);
            end
            OP_ADD, OP_ADC: begin
                ar = add8(acc_q, op_mem_data,
                          (op_code == OP_ADC) && borrow_inverse_flag_q);
                res_d = ar[7:0];
                arith_d = 1'b1;
                acc_wr_d = op_to_acc;
                mem_wr_d = !op_to_acc;
            end
            OP_XOR, OP_AND, OP_OR: begin
                if (op_code == OP_XOR) begin
                    res_d = acc_q ^ opnd_b;
                end else if (op_code == OP_AND) begin
                    res_d = acc_q & opnd_b;
                end else begin
                    res_d = acc_q | opnd_b;
                end
                null_wr_d = 1'b1;
                acc_wr_d = op_to_acc || op_use_imm;
                mem_wr_d = !(op_to_acc || op_use_imm);
            end
            OP_SWAP: begin
                res_d = {op_mem_data[3:0], op_mem_data[7:4]};
                acc_wr_d = op_to_acc;
                mem_wr_d = !op_to_acc;
            end
            OP_SKZ: begin
                skip_d = (op_mem_data == 8'h00);
            end
            OP_SKZ_MOV: begin
                acc_wr_d = 1'b1;
                skip_d = (op_mem_data == 8'h00);
            end
            OP_SKZ_BIT: begin
                skip_d = !op_mem_data[op_bit];
            end
            OP_CLR: begin
                res_d = `MXD_MEM_CLEAR;
                mem_wr_d = 1'b1;
            end
            OP_CLR_BIT: begin
                res_d[op_bit] = 1'b0;
                mem_wr_d = 1'b1;
            end
            OP_CPL: begin
                res_d = ~op_mem_data;
                null_wr_d = 1'b1;
                acc_wr_d = op_to_acc;
                mem_wr_d = !op_to_acc;
            end
            OP_DEC, OP_INC: begin
                res_d = (op_code == OP_INC) ? op_mem_data + 8'h01
                                            : op_mem_data - 8'h01;
                null_wr_d = 1'b1;
                acc_wr_d = op_to_acc;
                mem_wr_d = !op_to_acc;
            end
            OP_DAA: begin
                if (acc_q[3:0] > `MXD_BCD_LIMIT || nibble_carry_flag_q) begin
                    bcd_adj[3:0] = `MXD_BCD_STEP;
                end
                if (acc_q[7:4] > `MXD_BCD_LIMIT || borrow_inverse_flag_q) begin
                    bcd_adj[7:4] = `MXD_BCD_STEP;
                end
                bcd_sum = {1'b0, acc_q} + {1'b0, bcd_adj};
                res_d = bcd_sum[7:0];
                carry_wr_d = 1'b1;
                carry_d = borrow_inverse_flag_q | bcd_sum[8];
                mem_wr_d = 1'b1;
            end
            OP_MOV: begin
                res_d = op_to_acc ? op_mem_data : acc_q;
                acc_wr_d = op_to_acc;
                mem_wr_d = !op_to_acc;
            end
            OP_RL: begin
                res_d = {op_mem_data[6:0], op_mem_data[7]};
                acc_wr_d = op_to_acc;
                mem_wr_d = !op_to_acc;
            end
            OP_RLC: begin
                res_d = {op_mem_data[6:0], borrow_inverse_flag_q};
                carry_wr_d = 1'b1;
                carry_d = op_mem_data[7];
                acc_wr_d = op_to_acc;
                mem_wr_d = !op_to_acc;
            end
            default: begin
                res_d = op_mem_data;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Accumulator and flags
    // -------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= `MXD_ACC_RST;
        end else if (start && acc_wr_d) begin
            acc_q <= res_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            borrow_inverse_flag_q <= `MXD_FLAG_RST;
            nibble_carry_flag_q <= `MXD_FLAG_RST;
            signed_wrap_flag_q <= `MXD_FLAG_RST;
            all_bits_null_flag_q <= `MXD_FLAG_RST;
            signed_borrow_status_q <= `MXD_FLAG_RST;
            chained_null_status_q <= `MXD_FLAG_RST;
        end else if (start) begin
            if (arith_d) begin
                signed_wrap_flag_q <= ar[10];
                nibble_carry_flag_q <= ar[9];
                borrow_inverse_flag_q <= ar[8];
                all_bits_null_flag_q <= (ar[7:0] == 8'h00);
                signed_borrow_status_q <= ar[10] ^ ar[7];
            end else if (null_wr_d) begin
                all_bits_null_flag_q <= (res_d == 8'h00);
            end else if (carry_wr_d) begin
                borrow_inverse_flag_q <= carry_d;
            end
            if (subtract_d) begin
                chained_null_status_q <= (ar[7:0] == 8'h00);
            end
        end
    end

    // -------------------------------------------------------------
    // Memory write port, section select and table pointers
    // -------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_we_q <= 1'b0;
            mem_waddr_q <= '0;
            mem_wdata_q <= `MXD_MEM_CLEAR;
        end else begin
            mem_we_q <= (start && mem_wr_d) || (state_q == ST_TBL);
            if (state_q == ST_TBL) begin
                mem_wdata_q <= pm_rdata[7:0];
            end else if (start) begin
                mem_wdata_q <= res_d;
                mem_waddr_q <= op_ext ? {op_sect, op_addr}
                                      : {bank_sel, op_addr};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            table_pointer_low_q <= `MXD_PTR_RST;
            table_pointer_high_q <= `MXD_PTR_RST;
            table_high_latch_q <= `MXD_PTR_RST;
            pm_rd_q <= 1'b0;
            pm_addr_q <= '0;
        end else begin
            pm_rd_q <= start && (op_code == OP_TBL);
            if (start && op_code == OP_TBL) begin
                if (op_tbl_preinc) begin
                    table_pointer_low_q <= tp_low_next;
                end
                if (op_tbl_last) begin
                    pm_addr_q <= {{(PM_AW-8){1'b1}},
                        op_tbl_preinc ? tp_low_next
                                      : table_pointer_low_q};
                end else begin
                    pm_addr_q <= PM_AW'({table_pointer_high_q,
                        op_tbl_preinc ? tp_low_next : table_pointer_low_q});
                end
            end else if (tp_low_we) begin
                table_pointer_low_q <= tp_wdata;
            end
            if (tp_high_we) begin
                table_pointer_high_q <= tp_wdata;
            end
            if (state_q == ST_TBL) begin
                table_high_latch_q <= pm_rdata[15:8];
            end
        end
    end

    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            dummy_cycle_q <= 1'b0;
            op_done_q <= 1'b0;
        end else begin
            dummy_cycle_q <= 1'b0;
            op_done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start && op_code == OP_TBL) begin
                        state_q <= ST_TBL;
                    end else if (start && skip_d) begin
                        state_q <= ST_SKIP;
                        dummy_cycle_q <= 1'b1;
                    end else if (start) begin
                        op_done_q <= 1'b1;
                    end
                end
                ST_TBL, ST_SKIP: begin
                    state_q <= ST_IDLE;
                    op_done_q <= 1'b1;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence seq_skip_taken;
        start && skip_d;
    endsequence
    sequence seq_dummy_then_free;
        dummy_cycle_q && !op_ready ##1 op_ready && op_done_q;
    endsequence

    AST_SUB_BORROW: assert property (
        start && op_code == OP_SUB |=> borrow_inverse_flag_q ==
            ($past(acc_q) >= $past(opnd_b)))
        else $error("subtract carry wrong");
    AST_SUBI_ACC: assert property (
        start && op_code == OP_SUB && op_use_imm |=> !mem_we_q &&
            acc_q == 8'($past(acc_q) - $past(op_imm)))
        else $error("immediate subtract result wrong");
    AST_SWAP_MEM: assert property (
        start && op_code == OP_SWAP && !op_to_acc |=> mem_we_q &&
            mem_wdata_q == {$past(op_mem_data[3:0]),
                $past(op_mem_data[7:4])} && $stable(all_bits_null_flag_q))
        else $error("swap result wrong");
    AST_SKIP_TWO: assert property (
        seq_skip_taken |=> seq_dummy_then_free)
        else $error("skip did not take two cycles");
    AST_SKIP_ZERO: assert property (
        start && op_code == OP_SKZ |=>
            dummy_cycle_q == ($past(op_mem_data) == 8'h00))
        else $error("zero skip decision wrong");
    AST_SKIP_BIT: assert property (
        start && op_code == OP_SKZ_BIT && op_mem_data[op_bit] |=>
            !dummy_cycle_q && op_done_q)
        else $error("bit skip taken on set bit");
    AST_TBL_READ: assert property (
        start && op_code == OP_TBL |=> pm_rd_q ##1
            mem_we_q && mem_wdata_q == $past(pm_rdata[7:0]) &&
            table_high_latch_q == $past(pm_rdata[15:8]))
        else $error("table read data wrong");
    AST_TBL_LAST: assert property (
        start && op_code == OP_TBL && op_tbl_last |=>
            pm_addr_q[PM_AW-1:8] == {(PM_AW-8){1'b1}})
        else $error("last page address wrong");
    AST_TBL_PREINC: assert property (
        start && op_code == OP_TBL && op_tbl_preinc |=>
            table_pointer_low_q == 8'($past(table_pointer_low_q) + 8'h01)
            && pm_addr_q[7:0] == table_pointer_low_q)
        else $error("pointer preincrement wrong");
    AST_LOGIC_FLAGS: assert property (
        start && op_code == OP_XOR |=> $stable(borrow_inverse_flag_q) &&
            all_bits_null_flag_q == (8'($past(acc_q ^ opnd_b)) == 8'h00))
        else $error("logic flags wrong");
    AST_EXT_ADDR: assert property (
        start && op_ext && mem_wr_d |=> mem_we_q &&
            mem_waddr_q == {$past(op_sect), $past(op_addr)})
        else $error("extended section address wrong");
    AST_ADC_CARRY: assert property (
        start && op_code == OP_ADC |=> borrow_inverse_flag_q ==
            ((9'($past(acc_q)) + 9'($past(op_mem_data)) +
              9'($past(borrow_inverse_flag_q))) > 9'h0FF)
            && $stable(chained_null_status_q))
        else $error("add with carry flags wrong");
    AST_RLC: assert property (
        start && op_code == OP_RLC |=> borrow_inverse_flag_q ==
            $past(op_mem_data[7]) && mem_wdata_q[0] ==
            $past(borrow_inverse_flag_q) &&
            (!$past(op_to_acc) || acc_q[0] == mem_wdata_q[0]))
        else $error("rotate through carry wrong");

endmodule // mxd_datapath

// File: src/mxd_params.svh
/*
 * Constants of the execute datapath: reset values, adjust limits, timing.
 * Assumes inclusion by bare name from the datapath module.
 */
`ifndef MXD_PARAMS_SVH
`define MXD_PARAMS_SVH

`define MXD_ACC_RST 8'h00
`define MXD_FLAG_RST 1'b0
`define MXD_PTR_RST 8'h00
`define MXD_MEM_CLEAR 8'h00
`define MXD_BCD_LIMIT 4'h9
`define MXD_BCD_STEP 4'h6
`define MXD_NIBBLE_NULL 4'h0
`define MXD_SKIP_DUMMY_CYCLES 1

`endif

// File: src/mxd_pkg.sv
/*
 * Types of the execute datapath: operation codes and sequencer states.
 * Assumes the decoder upstream maps instruction words onto these codes.
 */
package mxd_pkg;

    typedef enum logic [4:0] {
        OP_SUB, OP_XOR, OP_AND, OP_OR, OP_ADD, OP_ADC, OP_SWAP,
        OP_SKZ, OP_SKZ_MOV, OP_SKZ_BIT, OP_TBL, OP_CLR, OP_CLR_BIT,
        OP_CPL, OP_DAA, OP_DEC, OP_INC, OP_MOV, OP_RL, OP_RLC
    } mxd_op_t;

    typedef enum logic [1:0] {
        ST_IDLE, ST_TBL, ST_SKIP
    } mxd_state_t;

endpackage

// File: tb/mxd_mem_model.sv
/*
 * Far-side model: program memory word source and data memory sink.
 * Assumes the datapath's registered strobes and default widths.
 */
`timescale 1ns/1ps

module mxd_mem_model (
    input wire logic core_clk,
    input wire logic pm_rd_q,
    input wire logic [11:0] pm_addr_q,
    input wire logic mem_we_q,
    input wire logic [10:0] mem_waddr_q,
    input wire logic [7:0] mem_wdata_q,
    output logic [15:0] pm_rdata
);
    logic [7:0] dm [0:2047];
    logic [15:0] junk_q = 16'h0000;

    // ------------------------------------------------------------
    // Program word, junk that changes every cycle outside reads
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        junk_q <= ~junk_q + 16'h1357;
    end
    assign pm_rdata = pm_rd_q ? {pm_addr_q[11:4] ^ 8'h3C,
        pm_addr_q[7:0] ^ 8'hA5} : junk_q;

    // ------------------------------------------------------------
    // Data memory write port
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (mem_we_q) begin
            dm[mem_waddr_q] <= mem_wdata_q;
        end
    end
endmodule // mxd_mem_model

// File: tb/mcu_execute_datapath_tail_bench.sv
/*
 * Self-checking bench of the execute datapath against an integer model.
 * Assumes the package, the header and the datapath compiled before it.
 */
`timescale 1ns/1ps

module mcu_execute_datapath_tail_bench;
    import mxd_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    logic op_ready;
    mxd_op_t op_code = OP_SUB;
    logic op_to_acc = 1'b0;
    logic op_use_imm = 1'b0;
    logic op_ext = 1'b0;
    logic op_tbl_last = 1'b0;
    logic op_tbl_preinc = 1'b0;
    logic [2:0] op_bit = 3'h0;
    logic [7:0] op_imm = 8'h00;
    logic [7:0] op_addr = 8'h00;
    logic [2:0] op_sect = 3'h0;
    logic [2:0] bank_sel = 3'h0;
    logic [7:0] op_mem_data = 8'h00;
    logic tp_low_we = 1'b0;
    logic tp_high_we = 1'b0;
    logic [7:0] tp_wdata = 8'h00;
    logic [15:0] pm_rdata;
    logic mem_we_q, pm_rd_q, dummy_cycle_q, op_done_q;
    logic [10:0] mem_waddr_q;
    logic [7:0] mem_wdata_q, acc_q, tpl_q, tph_q, thl_q;
    logic [11:0] pm_addr_q;
    logic cf_q, acf_q, ovf_q, zf_q, scf_q, czf_q;
    int errors = 0;
    int total_checks = 0;
    int acc, c, nib, wrap, z, sbs, chz, tpl, tph, thl;
    logic [31:0] seed = 32'h7227;

    always #25 core_clk = ~core_clk;

    mxd_datapath mxd_datapath_inst (.core_clk(core_clk), .rst_n(rst_n),
        .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
        .op_to_acc(op_to_acc), .op_use_imm(op_use_imm), .op_ext(op_ext),
        .op_tbl_last(op_tbl_last), .op_tbl_preinc(op_tbl_preinc),
        .op_bit(op_bit), .op_imm(op_imm), .op_addr(op_addr),
        .op_sect(op_sect), .bank_sel(bank_sel), .op_mem_data(op_mem_data),
        .tp_low_we(tp_low_we), .tp_high_we(tp_high_we),
        .tp_wdata(tp_wdata), .pm_rdata(pm_rdata), .mem_we_q(mem_we_q),
        .mem_waddr_q(mem_waddr_q), .mem_wdata_q(mem_wdata_q),
        .pm_rd_q(pm_rd_q), .pm_addr_q(pm_addr_q), .acc_q(acc_q),
        .table_pointer_low_q(tpl_q), .table_pointer_high_q(tph_q),
        .table_high_latch_q(thl_q), .borrow_inverse_flag_q(cf_q),
        .nibble_carry_flag_q(acf_q), .signed_wrap_flag_q(ovf_q),
        .all_bits_null_flag_q(zf_q), .signed_borrow_status_q(scf_q),
        .chained_null_status_q(czf_q), .dummy_cycle_q(dummy_cycle_q),
        .op_done_q(op_done_q));

    mxd_mem_model mxd_mem_model_inst (.core_clk(core_clk),
        .pm_rd_q(pm_rd_q), .pm_addr_q(pm_addr_q), .mem_we_q(mem_we_q),
        .mem_waddr_q(mem_waddr_q), .mem_wdata_q(mem_wdata_q),
        .pm_rdata(pm_rdata));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] roll();
        for (int k = 0; k < 8; k++) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        end
        return seed;
    endfunction

    function automatic logic [15:0] state_word();
        return {acc_q, cf_q, acf_q, ovf_q, zf_q, scf_q, czf_q};
    endfunction

    function automatic logic [15:0] model_word();
        return {acc[7:0], c[0], nib[0], wrap[0], z[0], sbs[0], chz[0]};
    endfunction

    task automatic tp_load(input logic [31:0] q);
        @(posedge core_clk);
        tp_low_we <= 1'b1;
        tp_wdata <= q[7:0];
        @(posedge core_clk);
        tp_low_we <= 1'b0;
        tp_high_we <= 1'b1;
        tp_wdata <= q[15:8];
        @(posedge core_clk);
        tp_high_we <= 1'b0;
        tpl = q[7:0];
        tph = q[15:8];
    endtask

    // ------------------------------------------------------------
    // One operation: drive, wait, predict, compare
    // ------------------------------------------------------------
    task automatic run_op(input int op, input int b0);
        int a, b, r, s, cin, kind, skip, lat, n_we, n_dm, pa_exp, bt;
        int n_busy, lat_exp;
        logic [31:0] q;
        logic [15:0] wd, wa, pa;
        bit imm, done;
        q = roll();
        imm = q[1] && op < 4;
        bt = q[7:5];
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= mxd_op_t'(op);
        op_to_acc <= q[0];
        op_use_imm <= imm;
        op_ext <= q[2];
        op_tbl_last <= q[3];
        op_tbl_preinc <= q[4];
        op_bit <= q[7:5];
        op_imm <= q[15:8];
        op_addr <= q[23:16];
        op_sect <= q[26:24];
        bank_sel <= q[29:27];
        op_mem_data <= b0[7:0];
        @(posedge core_clk);
        op_valid <= 1'b0;
        done = 0;
        lat = 0;
        n_we = 0;
        n_dm = 0;
        n_busy = 0;
        while (!done && lat < 5) begin
            @(negedge core_clk);
            lat++;
            if (mem_we_q === 1'b1) begin
                n_we++;
                wd = mem_wdata_q;
                wa = mem_waddr_q;
            end
            if (pm_rd_q === 1'b1) begin
                pa = pm_addr_q;
            end
            n_dm += (dummy_cycle_q === 1'b1);
            n_busy += (op_ready === 1'b0);
            done = (op_done_q === 1'b1);
        end
        a = acc;
        b = imm ? q[15:8] : b0;
        r = 0;
        skip = 0;
        kind = (q[0] || imm) ? 1 : 2;
        case (mxd_op_t'(op))
            OP_SUB: begin
                r = (a - b) & 255;
                c = (a + (b ^ 255) + 1) >> 8;
                nib = ((a & 15) + ((b ^ 15) & 15) + 1) >> 4;
                wrap = ((a ^ b) & (a ^ r) & 128) != 0;
                chz = r == 0;
            end
            OP_ADD, OP_ADC: begin
                cin = (op == OP_ADC) ? c : 0;
                s = a + b + cin;
                r = s & 255;
                c = s >> 8;
                nib = ((a & 15) + (b & 15) + cin) >> 4;
                wrap = (~(a ^ b) & (a ^ r) & 128) != 0;
            end
            OP_XOR: r = a ^ b;
            OP_AND: r = a & b;
            OP_OR: r = a | b;
            OP_SWAP: r = ((b & 15) << 4) | (b >> 4);
            OP_SKZ, OP_SKZ_MOV: skip = b == 0;
            OP_SKZ_BIT: skip = ((b >> bt) & 1) == 0;
            OP_TBL: begin
                tpl = q[4] ? (tpl + 1) & 255 : tpl;
                pa_exp = ((q[3] ? 15 : tph & 15) << 8) | tpl;
                r = (pa_exp & 255) ^ 165;
                thl = (pa_exp >> 4) ^ 60;
            end
            OP_CLR_BIT: r = b & ~(1 << bt) & 255;
            OP_CPL: r = b ^ 255;
            OP_DAA: begin
                r = a + (((a & 15) > 9 || nib) ? 6 : 0);
                r += ((a >> 4) > 9 || c) ? 96 : 0;
                c = c | (r > 255);
                r &= 255;
            end
            OP_DEC: r = (b - 1) & 255;
            OP_INC: r = (b + 1) & 255;
            OP_MOV: r = q[0] ? b : a;
            OP_RL: r = ((b << 1) | (b >> 7)) & 255;
            OP_RLC: begin
                r = ((b << 1) | c) & 255;
                c = b >> 7;
            end
            default: r = 0;
        endcase
        if (op == OP_SKZ_MOV) begin
            r = b;
        end
        if (op < 6 || op == OP_CPL || op == OP_DEC || op == OP_INC) begin
            z = r == 0;
            sbs = (op < 6 && op > 3 || op == 0) ? wrap ^ (r >> 7) : sbs;
        end
        if (op == OP_SKZ || op == OP_SKZ_BIT) begin
            kind = 0;
        end else if (op == OP_SKZ_MOV) begin
            kind = 1;
        end else if (op >= OP_TBL && op <= OP_CLR_BIT || op == OP_DAA) begin
            kind = 2;
        end
        if (kind == 1) begin
            acc = r;
        end
        chk(state_word(), model_word());
        chk(n_we, kind == 2);
        if (kind == 2) begin
            chk(wd, r);
            chk(wa, {q[2] ? q[26:24] : q[29:27], q[23:16]});
        end
        lat_exp = (skip || op == OP_TBL) ? 2 : 1;
        chk(lat * 16 + n_dm, lat_exp * 16 + skip);
        chk(n_busy, lat_exp - 1);
        chk(n_dm, (op == OP_SKZ) ? (b == 0) : skip);
        if (op == OP_TBL) begin
            chk(pa, pa_exp);
            chk(tph_q, tph[7:0]);
            chk({tpl_q, thl_q}, {tpl[7:0], thl[7:0]});
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        {acc, c, nib, wrap, z, sbs, chz, tpl, tph, thl} = '0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk(state_word(), 16'h0000);
        for (int i = 0; i < 400; i++) begin
            q = roll();
            if (i % 7 == 0) begin
                tp_load(q);
            end
            run_op(i < 40 ? i % 20 : q[20:16] % 20, q[27] ? q[15:8] : 0);
        end
        complete_run();
    end

    initial begin
        #1000000;
        errors++;
        complete_run();
    end
endmodule // mcu_execute_datapath_tail_bench
